// ---- logic/adc_link_pkg.sv ----
package adc_link_pkg;

  // Result word and local clock
  localparam int RESULT_W = 13;
  localparam int BIT_CNT_W = 4;
  localparam real CLK_PERIOD_NS = 25.0;

  // Link timing, in nanoseconds as specified
  localparam real T_QUIET_NS = 10.0;
  localparam real T_TAIL_NS = 20.0;
  localparam real T_CNVH_NS = 25.0;
  localparam real T_CYC_NS = 200.0;
  localparam real T_SCK_MIN_NS = 9.4;
  localparam real T_DATA_VALID_NS = 5.0;
  localparam real T_RELEASE_NS = 5.0;

  // Least time: round up, never below one cycle
  function automatic int cycles_min(input real t_ns);
    int c;
    c = int'($ceil(t_ns / CLK_PERIOD_NS));
    return (c < 1) ? 1 : c;
  endfunction

  // Longest time: round down, never below one cycle
  function automatic int cycles_max(input real t_ns);
    int c;
    c = int'($floor(t_ns / CLK_PERIOD_NS));
    return (c < 1) ? 1 : c;
  endfunction

  localparam int QUIET_CYC = cycles_min(T_QUIET_NS);
  localparam int TAIL_CYC = cycles_min(T_TAIL_NS);
  localparam int CNVH_CYC = cycles_min(T_CNVH_NS);
  localparam int CYC_CYC = cycles_min(T_CYC_NS);
  localparam int DATA_VALID_CYC = cycles_max(T_DATA_VALID_NS);
  localparam int RELEASE_CYC = cycles_max(T_RELEASE_NS);

  // Values after reset, and the last bit count
  localparam logic [RESULT_W-1:0] RESULT_RESET = 13'h0000;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_RESET = 4'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 4'hD;

  // Signalling standard chosen by the strap
  typedef enum logic [1:0] {
    IO_CMOS = 2'h0,
    IO_LVDS = 2'h1,
    IO_LVDS_LP = 2'h3
  } io_mode_type;

  function automatic io_mode_type decode_io_mode(input logic level,
                                                 input logic floating);
    if (floating) begin
      return IO_LVDS_LP;
    end
    return level ? IO_LVDS : IO_CMOS;
  endfunction

endpackage

// ---- logic/adc_link_if.sv ----
interface adc_link_if;

  logic convert_strobe_n;
  logic sck_pos;
  logic sck_pos_oe;
  logic sck_neg;
  logic sck_neg_oe;
  logic serial_out_pos;
  logic serial_out_pos_oe;
  logic serial_out_neg;
  logic serial_out_neg_oe;

  // Line levels; a released line is pulled low
  logic sck_line;
  logic data_line;

  assign sck_line = sck_pos_oe & sck_pos;
  assign data_line = serial_out_pos_oe & serial_out_pos;

  modport device (
    input convert_strobe_n,
    input sck_line,
    output serial_out_pos,
    output serial_out_pos_oe,
    output serial_out_neg,
    output serial_out_neg_oe
  );

  modport host (
    output convert_strobe_n,
    output sck_pos,
    output sck_pos_oe,
    output sck_neg,
    output sck_neg_oe,
    input data_line
  );

endinterface

// ---- logic/sample_fifo.sv ----
module sample_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("sample_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_idx;
    logic [AW-1:0] rd_idx;
    logic [AW:0] count;
  } fifo_reg_type;

  fifo_reg_type r;
  fifo_reg_type next_r;
  logic push;
  logic pop;

  assign in_ready_o = (r.count != (AW+1)'(DEPTH));
  assign out_valid_o = (r.count != '0);
  assign out_data_o = r.mem[r.rd_idx];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wr_idx] = in_data_i;
      next_r.wr_idx = r.wr_idx + 1'b1;
    end
    if (pop) begin
      next_r.rd_idx = r.rd_idx + 1'b1;
    end
    if (push && !pop) begin
      next_r.count = r.count + 1'b1;
    end else if (pop && !push) begin
      next_r.count = r.count - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule

// ---- logic/adc_device_end.sv ----
// Operation
// [R1] Strobe high keeps tracking the analog input
// [R2] Strobe fall starts conversion and data output
// [R3] Host keeps shift clock quiet 10 ns
// [R4] Host waits 20 ns before raising strobe
// [R5] First bit valid soon after strobe fall
// [R6] Data output released soon after strobe rise
// [R7] Each shift clock fall advances, MSB first
// [R8] Host shift clock period at least 9.4 ns
// [R9] Strap selects CMOS, LVDS or low-power LVDS
// [R10] CMOS: host uses positive lines only
// [R11] LVDS: differential data out, differential clock in; the device reads only the positive clock line
// [R12] Strobe behaves the same in every mode
// [R13] Result is 13-bit two's complement word
// [R14] Frame shifts out the preceding conversion
// [R15] Host gives thirteen shift clocks per frame
module adc_device_end
  import adc_link_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // Analog stand-in: signed value at the input
  input wire logic [RESULT_W-1:0] SAMPLE_I,
  // Signalling strap pin
  input wire logic IO_SEL_LEVEL_I,
  input wire logic IO_SEL_FLOAT_I,
  // Status
  output logic SAMPLING_O,
  output logic [RESULT_W-1:0] RESULT_O,
  output logic [BIT_CNT_W-1:0] BITS_SENT_O,
  output logic SHORT_FRAME_O,
  output logic [1:0] IO_MODE_O,
  output logic LOW_POWER_O,
  // Link
  adc_link_if.device LINK
);

  typedef enum logic {
    ST_ACQUIRE = 1'b0,
    ST_CONVERT = 1'b1
  } dev_state_type;

  typedef struct packed {
    logic [1:0] strobe_sync;
    logic [1:0] sck_sync;
    logic [1:0] level_sync;
    logic [1:0] float_sync;
    logic strobe_prev;
    logic sck_prev;
    io_mode_type mode;
    dev_state_type state;
    logic [RESULT_W-1:0] track;
    logic [RESULT_W-1:0] result;
    logic [RESULT_W-1:0] shift;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic drive;
    logic short_frame;
    logic data_neg;
    logic drive_neg;
    logic low_power;
  } dev_reg_type;

  localparam dev_reg_type DEV_RESET = '{
    strobe_sync: 2'h3,
    sck_sync: 2'h0,
    level_sync: 2'h0,
    float_sync: 2'h0,
    strobe_prev: 1'b1,
    sck_prev: 1'b0,
    mode: IO_CMOS,
    state: ST_ACQUIRE,
    track: RESULT_RESET,
    result: RESULT_RESET,
    shift: RESULT_RESET,
    bit_cnt: BIT_CNT_RESET,
    drive: 1'b0,
    short_frame: 1'b0,
    data_neg: 1'b1,
    drive_neg: 1'b0,
    low_power: 1'b0
  };

  dev_reg_type r;
  dev_reg_type next_r;

  // A one-bit word cannot shift, and a counter that wraps before the
  // last bit would let a frame shift forever
  generate
    if (RESULT_W < 2) begin : g_bad_width
      $error("result word needs two bits at least");
    end
    if ((1 << BIT_CNT_W) <= RESULT_W) begin : g_bad_count
      $error("bit counter too narrow for the result word");
    end
    if (int'(BIT_CNT_LAST) != RESULT_W) begin : g_bad_last
      $error("last bit count must equal the word length");
    end
  endgenerate

  // Edge finders over a synchronised line and its copy one cycle older
  function automatic logic line_fell(input logic prev, input logic now);
    return prev & ~now;
  endfunction

  function automatic logic line_rose(input logic prev, input logic now);
    return ~prev & now;
  endfunction

  // One step of the output shifter; zeros enter at the bottom
  function automatic logic [RESULT_W-1:0] shift_step(
    input logic [RESULT_W-1:0] word
  );
    return {word[RESULT_W-2:0], 1'b0};
  endfunction

  logic strobe_fall;
  logic strobe_rise;
  logic sck_fall;

  // Edges are found on the second synchroniser stage only
  assign strobe_fall = line_fell(r.strobe_prev, r.strobe_sync[1]);
  assign strobe_rise = line_rose(r.strobe_prev, r.strobe_sync[1]);
  assign sck_fall = line_fell(r.sck_prev, r.sck_sync[1]);

  always_comb begin
    next_r = r;

    // The strobe path never looks at the mode [R12]
    next_r.strobe_sync = {r.strobe_sync[0], LINK.convert_strobe_n};
    next_r.sck_sync = {r.sck_sync[0], LINK.sck_line};
    next_r.level_sync = {r.level_sync[0], IO_SEL_LEVEL_I};
    next_r.float_sync = {r.float_sync[0], IO_SEL_FLOAT_I};
    next_r.strobe_prev = r.strobe_sync[1];
    next_r.sck_prev = r.sck_sync[1];

    // Strap is static; re-decoding each cycle also covers reset release
    next_r.mode = decode_io_mode(r.level_sync[1], r.float_sync[1]); // [R9]

    case (r.state)
      ST_ACQUIRE: begin
        // Shift clock edges count for nothing while sampling
        if (r.strobe_sync[1]) begin
          next_r.track = SAMPLE_I; // [R1]
        end
        if (strobe_fall) begin
          // Held sample becomes the new signed result [R13]
          next_r.result = r.track;
          // The frame carries the conversion before this one [R14]
          next_r.shift = r.result;
          next_r.drive = 1'b1; // [R2] [R5]
          next_r.bit_cnt = BIT_CNT_RESET;
          next_r.short_frame = 1'b0;
          next_r.state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (strobe_rise) begin
          // Rise wins over a shift clock fall in the same cycle
          next_r.drive = 1'b0; // [R6]
          next_r.short_frame = (r.bit_cnt < BIT_CNT_LAST);
          next_r.state = ST_ACQUIRE;
        end else if (sck_fall && r.bit_cnt < BIT_CNT_LAST) begin
          // Shifting stops once all bits are out; the shifter then holds zero
          next_r.shift = shift_step(r.shift); // [R7]
          next_r.bit_cnt = r.bit_cnt + 1'b1;
        end
      end
      default: begin
        // Unreachable with two states; lands safely in sampling
        next_r.drive = 1'b0;
        next_r.state = ST_ACQUIRE;
      end
    endcase

    // Both lines of the pair come straight from flops, so they switch on
    // the same edge; the enable follows the strap mode [R11]
    next_r.data_neg = ~next_r.shift[RESULT_W-1];
    next_r.drive_neg = next_r.drive & (next_r.mode != IO_CMOS);
    next_r.low_power = (next_r.mode == IO_LVDS_LP); // [R9]
  end

  // Synchronous reset only; the strobe flops start high so that no false
  // fall is seen when reset lets go
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      r <= DEV_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Data pins follow the registers directly, so output is one cycle
  // after the internal decision; the nanosecond limits map to that cycle
  assign LINK.serial_out_pos = r.shift[RESULT_W-1]; // [R7]
  assign LINK.serial_out_pos_oe = r.drive; // [R5] [R6]
  assign LINK.serial_out_neg = r.data_neg; // [R11]
  assign LINK.serial_out_neg_oe = r.drive_neg; // [R11]

  // Status follows the registers; none of it feeds back into the link
  assign SAMPLING_O = (r.state == ST_ACQUIRE);
  assign RESULT_O = r.result;
  assign BITS_SENT_O = r.bit_cnt;
  assign SHORT_FRAME_O = r.short_frame;
  assign IO_MODE_O = r.mode;
  assign LOW_POWER_O = r.low_power;

endmodule

// ---- logic/adc_host_end.sv ----
module adc_host_end
  import adc_link_pkg::*;
#(
  parameter int HALF_CYC = 4,
  parameter int LEAD_CYC = 8,
  parameter int HIGH_CYC = 8,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // Control
  input wire logic ENABLE_I,
  input wire logic LVDS_I,
  output logic BUSY_O,
  // Received words
  output logic [RESULT_W-1:0] DATA_O,
  output logic DATA_VALID_O,
  input wire logic DATA_READY_I,
  // Link
  adc_link_if.host LINK
);

  // Device sees edges three cycles late and the data returns two later
  generate
    if (HALF_CYC < 4 || HALF_CYC > 255) begin : g_bad_half
      $error("HALF_CYC must lie in 4..255");
    end
    if (2.0 * HALF_CYC * CLK_PERIOD_NS < T_SCK_MIN_NS) begin : g_bad_sck
      $error("shift clock period below minimum");
    end
    if (LEAD_CYC < QUIET_CYC || LEAD_CYC < 4 || LEAD_CYC > 255)
    begin : g_bad_lead
      $error("LEAD_CYC too short or too long");
    end
    if (HIGH_CYC < CNVH_CYC || HIGH_CYC > 255) begin : g_bad_high
      $error("HIGH_CYC out of range");
    end
  endgenerate

  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_QUIET = 3'h1,
    HS_HIGH = 3'h3,
    HS_LOW = 3'h2,
    HS_TAIL = 3'h6
  } host_state_type;

  typedef struct packed {
    host_state_type state;
    logic [7:0] cnt;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic strobe_n;
    logic sck;
    logic [1:0] data_sync;
    logic [RESULT_W-1:0] word;
    logic push;
  } host_reg_type;

  localparam host_reg_type HOST_RESET = '{
    state: HS_IDLE,
    cnt: 8'h00,
    bit_cnt: BIT_CNT_RESET,
    strobe_n: 1'b1,
    sck: 1'b0,
    data_sync: 2'h0,
    word: RESULT_RESET,
    push: 1'b0
  };

  host_reg_type r;
  host_reg_type next_r;
  logic fifo_ready;

  always_comb begin
    next_r = r;
    next_r.push = 1'b0;
    next_r.data_sync = {r.data_sync[0], LINK.data_line};
    next_r.cnt = r.cnt + 8'h01;
    case (r.state)
      HS_IDLE: begin
        // A frame starts only with room for its word: back-pressure
        if (r.cnt >= 8'(HIGH_CYC - 1) && ENABLE_I && fifo_ready) begin
          next_r.strobe_n = 1'b0;
          next_r.cnt = 8'h00;
          next_r.bit_cnt = BIT_CNT_RESET;
          next_r.state = HS_QUIET;
        end else if (r.cnt >= 8'(HIGH_CYC - 1)) begin
          next_r.cnt = r.cnt;
        end
      end
      HS_QUIET: begin
        if (r.cnt >= 8'(LEAD_CYC - 1)) begin // [R3]
          next_r.sck = 1'b1;
          next_r.cnt = 8'h00;
          next_r.state = HS_HIGH;
        end
      end
      HS_HIGH: begin
        if (r.cnt >= 8'(HALF_CYC - 1)) begin // [R8]
          next_r.sck = 1'b0;
          next_r.cnt = 8'h00;
          next_r.word = {r.word[RESULT_W-2:0], r.data_sync[1]};
          next_r.bit_cnt = r.bit_cnt + 1'b1;
          next_r.state = HS_LOW;
        end
      end
      HS_LOW: begin
        if (r.cnt >= 8'(HALF_CYC - 1)) begin
          next_r.cnt = 8'h00;
          if (r.bit_cnt == BIT_CNT_LAST) begin // [R15]
            next_r.state = HS_TAIL;
          end else begin
            next_r.sck = 1'b1;
            next_r.state = HS_HIGH;
          end
        end
      end
      HS_TAIL: begin
        if (r.cnt >= 8'(TAIL_CYC - 1)) begin // [R4]
          next_r.strobe_n = 1'b1;
          next_r.push = 1'b1;
          next_r.cnt = 8'h00;
          next_r.state = HS_IDLE;
        end
      end
      default: begin
        next_r = HOST_RESET;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      r <= HOST_RESET;
    end else begin
      r <= next_r;
    end
  end

  sample_fifo #(
    .WIDTH(RESULT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .in_valid_i(r.push),
    .in_data_i(r.word),
    .in_ready_o(fifo_ready),
    .out_valid_o(DATA_VALID_O),
    .out_data_o(DATA_O),
    .out_ready_i(DATA_READY_I)
  );

  assign LINK.convert_strobe_n = r.strobe_n;
  assign LINK.sck_pos = r.sck; // [R10]
  assign LINK.sck_pos_oe = 1'b1;
  assign LINK.sck_neg = ~r.sck; // [R11]
  assign LINK.sck_neg_oe = LVDS_I; // [R10] [R11]
  assign BUSY_O = (r.state != HS_IDLE);

endmodule

// ---- dv/adc_link_properties.sv ----
module adc_link_properties (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // Link signals
  input wire logic convert_strobe_n,
  input wire logic sck_pos,
  input wire logic sck_neg,
  input wire logic sck_neg_oe,
  input wire logic serial_out_pos,
  input wire logic serial_out_pos_oe,
  input wire logic serial_out_neg,
  input wire logic serial_out_neg_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  // Falls seen in this frame, cleared while the strobe is high
  logic sck_q;
  logic [3:0] falls;
  always_ff @(posedge CLK_SYS_I) begin
    sck_q <= sck_pos;
    if (RST_I || convert_strobe_n) begin
      falls <= 4'h0;
    end else if (sck_q && !sck_pos) begin
      falls <= falls + 4'h1;
    end
  end

  oe_on_fall_a: assert property ($fell(convert_strobe_n) |->
    !serial_out_pos_oe [*3] ##1 serial_out_pos_oe)
    else $error("data enable timing after strobe fall");
  oe_release_a: assert property ($rose(convert_strobe_n) |->
    serial_out_pos_oe [*3] ##1 !serial_out_pos_oe)
    else $error("data release timing after strobe rise");
  idle_quiet_a: assert property (convert_strobe_n &&
    $past(convert_strobe_n, 5) |-> !serial_out_pos_oe && !sck_pos)
    else $error("activity while sampling");
  lead_quiet_a: assert property ($fell(convert_strobe_n) |->
    !sck_pos [*8] ##1 sck_pos)
    else $error("shift clock lead time wrong");
  bit_hold_a: assert property ($fell(sck_pos) |->
    $stable(serial_out_pos) [*3])
    else $error("data bit moved too early");
  frame_count_a: assert property ($rose(convert_strobe_n) |->
    falls == 4'hD)
    else $error("frame without thirteen shift clocks");
  tail_gap_a: assert property ($rose(convert_strobe_n) |->
    !$past(sck_pos) && !$past(sck_pos, 2))
    else $error("strobe rose right after clock activity");
  sck_width_a: assert property ($rose(sck_pos) |->
    sck_pos [*4] ##1 !sck_pos)
    else $error("shift clock high time wrong");
  diff_data_a: assert property (serial_out_neg_oe |->
    serial_out_pos_oe && serial_out_neg != serial_out_pos)
    else $error("data pair not complementary");
  diff_clock_a: assert property (sck_neg_oe |->
    sck_neg != sck_pos)
    else $error("clock pair not complementary");
endmodule

// ---- dv/tb_sar_adc_serial_readout.sv ----
module tb_sar_adc_serial_readout
  import adc_link_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic CLK_SYS_I = 1'b0;
  logic RST_I = 1'b1;
  logic en = 1'b0, lvds = 1'b0, rdy = 1'b0, hold = 1'b1, freeze = 1'b0;
  logic lvl = 1'b0, flt = 1'b0, cs2 = 1'b1, sck2 = 1'b0;
  logic busy, dval, short2, samp2, lp;
  logic [1:0] mode;
  logic [3:0] bits2;
  logic [RESULT_W-1:0] smp = '0;
  logic [RESULT_W-1:0] dout, last, w, a, res2;
  logic [RESULT_W-1:0] expq[$];
  io_mode_type modes[3] = '{IO_CMOS, IO_LVDS, IO_LVDS_LP};
  int errors = 0, n_checks = 0, cyc = 0, falls = 0, f0;
  int seed = 32'hC20CC266;

  adc_link_if link ();
  adc_link_if link2 ();

  // Second link: the bench plays a host that may break the frame rules
  assign link2.convert_strobe_n = cs2;
  assign link2.sck_pos = sck2;
  assign link2.sck_pos_oe = 1'b1;
  assign link2.sck_neg = ~sck2;
  assign link2.sck_neg_oe = 1'b0;

  adc_host_end adc_host_end_i (
    .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .ENABLE_I(en), .LVDS_I(lvds),
    .BUSY_O(busy), .DATA_O(dout), .DATA_VALID_O(dval), .DATA_READY_I(rdy),
    .LINK(link.host));
  adc_device_end adc_device_end_i (
    .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .SAMPLE_I(smp),
    .IO_SEL_LEVEL_I(lvl), .IO_SEL_FLOAT_I(flt), .SAMPLING_O(),
    .RESULT_O(), .BITS_SENT_O(), .SHORT_FRAME_O(), .IO_MODE_O(mode),
    .LOW_POWER_O(lp), .LINK(link.device));
  adc_device_end spare_adc_device_end_i (
    .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .SAMPLE_I(smp),
    .IO_SEL_LEVEL_I(lvl), .IO_SEL_FLOAT_I(flt), .SAMPLING_O(samp2),
    .RESULT_O(res2), .BITS_SENT_O(bits2), .SHORT_FRAME_O(short2),
    .IO_MODE_O(), .LOW_POWER_O(), .LINK(link2.device));
  adc_link_properties adc_link_properties_i (
    .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
    .convert_strobe_n(link.convert_strobe_n), .sck_pos(link.sck_pos),
    .sck_neg(link.sck_neg), .sck_neg_oe(link.sck_neg_oe),
    .serial_out_pos(link.serial_out_pos),
    .serial_out_pos_oe(link.serial_out_pos_oe),
    .serial_out_neg(link.serial_out_neg),
    .serial_out_neg_oe(link.serial_out_neg_oe));

  always #12.5 CLK_SYS_I = ~CLK_SYS_I;

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_word(input string s, input logic [RESULT_W-1:0] e,
                          input logic [RESULT_W-1:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask

  task automatic chk_stat(input string s, input logic [15:0] e,
                          input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask

  // One frame on the second link with n shift clocks of 200 ns
  task automatic frame2(input int n);
    w = '0;
    cs2 = 1'b0;
    repeat (8) @(negedge CLK_SYS_I);
    chk_stat("sampling", 16'h0, {15'h0, samp2});
    chk_word("result", smp, res2);
    for (int i = 0; i < n; i++) begin
      sck2 = 1'b1;
      repeat (4) @(negedge CLK_SYS_I);
      w = {w[RESULT_W-2:0], link2.data_line};
      sck2 = 1'b0;
      repeat (4) @(negedge CLK_SYS_I);
    end
    repeat (2) @(negedge CLK_SYS_I);
    chk_stat("bits", (n > 13) ? 16'hD : 16'(n), {12'h0, bits2});
    cs2 = 1'b1;
    repeat (8) @(negedge CLK_SYS_I);
    chk_stat("sampling", 16'h1, {15'h0, samp2});
    chk_stat("short", {15'h0, n < 13}, {15'h0, short2});
  endtask

  // Input only moves while sampling, so each frame converts a fixed value
  always @(negedge CLK_SYS_I) begin
    if (!freeze && link.convert_strobe_n === 1'b1) begin
      smp <= RESULT_W'($random(seed));
    end
    rdy <= hold ? 1'b0 : 1'($random(seed));
  end

  always @(negedge link.convert_strobe_n) begin
    if (!RST_I) begin
      expq.push_back(last);
      last = smp;
      falls++;
    end
  end

  always @(posedge CLK_SYS_I) begin
    if (!RST_I && dval === 1'b1 && rdy === 1'b1) begin
      chk_word("word", expq.size() > 0 ? expq.pop_front() : 'x, dout);
    end
  end

  always @(posedge CLK_SYS_I) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end

  initial begin
    last = RESULT_RESET;
    repeat (2) @(posedge CLK_SYS_I);
    @(negedge CLK_SYS_I);
    RST_I = 1'b0;
    for (int m = 0; m < 3; m++) begin
      {flt, lvl} = (m == 2) ? 2'b10 : 2'(m);
      repeat (5) @(negedge CLK_SYS_I);
      chk_stat("mode", {14'h0, modes[m]}, {14'h0, mode});
      chk_stat("low power", {15'h0, m == 2}, {15'h0, lp});
    end
    lvds = 1'b1;
    hold = 1'b0;
    en = 1'b1;
    wait (falls >= 3);
    @(negedge CLK_SYS_I);
    {flt, lvl} = 2'b01;
    wait (falls >= 5);
    @(negedge CLK_SYS_I);
    lvds = 1'b0;
    {flt, lvl} = 2'b00;
    wait (falls >= 8);
    @(negedge CLK_SYS_I);
    en = 1'b0;
    repeat (2) @(negedge CLK_SYS_I);
    wait (busy === 1'b0 && expq.size() == 0);
    @(negedge CLK_SYS_I);
    // Stall the reader: the host must stop once the buffer is full
    hold = 1'b1;
    f0 = falls;
    en = 1'b1;
    repeat (1600) @(negedge CLK_SYS_I);
    chk_stat("frames", 16'h8, 16'(falls - f0));
    chk_stat("busy", 16'h0, {15'h0, busy});
    en = 1'b0;
    hold = 1'b0;
    wait (busy === 1'b0 && expq.size() == 0);
    @(negedge CLK_SYS_I);
    chk_stat("valid", 16'h0, {15'h0, dval});
    freeze = 1'b1;
    @(negedge CLK_SYS_I);
    smp = RESULT_W'($random(seed));
    a = smp;
    frame2(13);
    chk_word("first", RESULT_RESET, w);
    smp = RESULT_W'($random(seed));
    frame2(13);
    chk_word("serial", a, w);
    a = smp;
    smp = RESULT_W'($random(seed));
    frame2(5);
    chk_word("partial", a >> 8, w);
    a = smp;
    frame2(15);
    chk_word("overrun", a << 2, w);
    print_verdict();
  end
endmodule
